// ---- rtl/fsirq_pkg.sv ----
package fsirq_pkg;

  localparam logic [31:0] MASK_OFFSET = 32'h0000_0018;
  localparam logic [31:0] PEEK_OFFSET = 32'h0000_001c;
  localparam logic [31:0] POP_OFFSET = 32'h0000_0020;
  localparam logic [31:0] FLAGS_OFFSET = 32'h0000_0014;
  localparam logic [31:0] MODE_OFFSET = 32'h0000_0024;

  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

  // Bits of the mask register that are implemented here
  localparam logic [31:0] MASK_IMPL = 32'h001c_fcfe;
  // Bits usable only as a device, only as a host
  localparam logic [31:0] DEV_ONLY = 32'h001c_fcc0;
  localparam logic [31:0] HOST_ONLY = 32'h0000_0020;

  localparam int BIT_ISO_IN_INC = 20;
  localparam int BIT_OUT_EP = 19;
  localparam int BIT_IN_EP = 18;
  localparam int BIT_EOPF = 15;
  localparam int BIT_ISO_DROP = 14;
  localparam int BIT_ENUM = 13;
  localparam int BIT_BUS_RST = 12;
  localparam int BIT_SUSP = 11;
  localparam int BIT_ESUSP = 10;
  localparam int BIT_GOUT_NAK = 7;
  localparam int BIT_GNPIN_NAK = 6;
  localparam int BIT_NPTXFE = 5;
  localparam int BIT_RXFNE = 4;
  localparam int BIT_SOF = 3;
  localparam int BIT_OTG = 2;
  localparam int BIT_MODE_FAULT = 1;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic [2:0] size;
  } fsirq_addr_t;

endpackage

// ---- rtl/fsirq_core.sv ----
`timescale 1ns/10ps
// Function
// - Mask bit 20 gates iso IN incomplete interrupt, device mode only.
// - Mask bit 19 gates aggregated OUT endpoint interrupt, device mode only.
// - Mask bit 18 gates aggregated IN endpoint interrupt, device mode only.
// - Mask bit 15 gates end of periodic frame interrupt, device only.
// - Mask bit 14 gates iso OUT dropped interrupt, device mode only.
// - Mask bit 13 gates enumeration done interrupt, device mode only.
// - Mask bit 12 gates bus reset interrupt, device mode only.
// - Mask bit 11 gates bus suspend interrupt, device mode only.
// - Mask bit 10 gates early suspend interrupt, device mode only.
// - Mask bit 7 gates global OUT NAK effective interrupt, device only.
// - Mask bit 6 gates global non-periodic IN NAK interrupt, device only.
// - Mask bit 5 gates non-periodic transmit FIFO empty, host only.
// - Mask bit 4 gates receive FIFO non-empty, both modes.
// - Mask bit 3 gates start of frame, both modes.
// - Mask bit 2 gates dual-role event summary, both modes.
// - Mask bit 1 gates mode fault, both modes.
// - Peek register at 0x1c returns FIFO head, FIFO unchanged.
// - Pop register at 0x20 returns FIFO head and removes it.
// - Masking blocks only the output; the flag still sets.
// - A mask write with a wrong-mode bit set sets mode fault and has no other effect.
module fsirq_core #(
  parameter int ENTRY_W = 21,
  parameter int DEPTH = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic host_mode,
  input wire logic [31:0] event_pulses,
  input wire logic rx_push,
  input wire logic [ENTRY_W-1:0] rx_entry,
  output logic rx_full,
  output logic irq
);

  localparam int AW = $clog2(DEPTH);

  logic [31:0] mask_reg;
  logic [31:0] flags_reg;
  logic [ENTRY_W-1:0] fifo_mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [31:0] hrdata_reg;
  logic mode_sync1_reg;
  logic mode_sync2_reg;
  logic aph_valid_reg;
  fsirq_pkg::fsirq_addr_t aph_reg;

  logic rx_empty;
  logic fault_now;
  logic do_write;
  logic do_pop;
  logic do_push;
  logic [31:0] allowed_bits;
  logic [31:0] head_word;
  logic [31:0] flags_set;
  logic [31:0] flags_clr;

  // Writes of bits usable only in the other mode are dropped
  function automatic logic [31:0] mode_allowed(input logic is_host);
    mode_allowed = is_host ? (fsirq_pkg::MASK_IMPL & ~fsirq_pkg::DEV_ONLY)
                           : (fsirq_pkg::MASK_IMPL & ~fsirq_pkg::HOST_ONLY);
  endfunction

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign rx_empty = (count_reg == '0);
  assign rx_full = (count_reg == (AW+1)'(DEPTH));
  assign head_word = rx_empty ? fsirq_pkg::STATUS_RESET
                              : 32'(fifo_mem[rd_ptr_reg]);
  assign allowed_bits = mode_allowed(mode_sync2_reg);

  // Mode pin comes from the protocol engine clocked elsewhere
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_sync1_reg <= 1'b0;
      mode_sync2_reg <= 1'b0;
    end else if (clk_en) begin
      mode_sync1_reg <= host_mode;
      mode_sync2_reg <= mode_sync1_reg;
    end
  end

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_valid_reg <= 1'b0;
      aph_reg <= '0;
    end else if (clk_en && hready) begin
      aph_valid_reg <= hsel && htrans[1];
      aph_reg <= '{addr: haddr, write: hwrite, size: hsize};
    end
  end

  assign do_write = clk_en && aph_valid_reg && aph_reg.write
                    && aph_reg.addr == fsirq_pkg::MASK_OFFSET;
  // Writing a bit of the wrong mode counts as a faulting access
  assign fault_now = do_write && |(hwdata & fsirq_pkg::MASK_IMPL & ~allowed_bits);
  assign do_pop = clk_en && aph_valid_reg && !aph_reg.write
                  && aph_reg.addr == fsirq_pkg::POP_OFFSET && !rx_empty;
  assign do_push = clk_en && rx_push && !rx_full;

  // Only implemented, mode-legal bits change; reserved bits stay zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_reg <= fsirq_pkg::MASK_RESET;
    end else if (do_write && !fault_now) begin
      mask_reg <= (mask_reg & ~allowed_bits) | (hwdata & allowed_bits);
    end
  end

  // Flags set regardless of mask; set wins over a write-one clear
  always_comb begin
    flags_set = event_pulses & fsirq_pkg::MASK_IMPL;
    // A mode-fault event from the engine and a faulting write both raise the flag
    flags_set[fsirq_pkg::BIT_MODE_FAULT] = event_pulses[fsirq_pkg::BIT_MODE_FAULT]
                                           | fault_now;
    flags_set[fsirq_pkg::BIT_RXFNE] = 1'b0;
    flags_clr = '0;
    if (clk_en && aph_valid_reg && aph_reg.write
        && aph_reg.addr == fsirq_pkg::FLAGS_OFFSET) begin
      flags_clr = hwdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_reg <= fsirq_pkg::STATUS_RESET;
    end else if (clk_en) begin
      flags_reg <= (flags_reg & ~flags_clr) | flags_set;
    end
  end

  always_ff @(posedge hclk) begin
    if (do_push) begin
      fifo_mem[wr_ptr_reg] <= rx_entry;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (do_pop && !do_push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  // Read data registered at the edge ending the address phase, valid during the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= '0;
    end else if (clk_en && hready) begin
      hrdata_reg <= '0;
      if (hsel && htrans[1] && !hwrite) begin
        unique case (haddr)
          fsirq_pkg::MASK_OFFSET: hrdata_reg <= mask_reg;
          fsirq_pkg::FLAGS_OFFSET: begin
            hrdata_reg <= flags_reg;
            hrdata_reg[fsirq_pkg::BIT_RXFNE] <= !rx_empty;
          end
          fsirq_pkg::PEEK_OFFSET: hrdata_reg <= head_word;
          fsirq_pkg::POP_OFFSET: hrdata_reg <= head_word;
          fsirq_pkg::MODE_OFFSET: hrdata_reg <= {31'h0, mode_sync2_reg};
          default: hrdata_reg <= '0;
        endcase
      end
    end
  end

  // Rx non-empty flag is live; mode-illegal enables contribute nothing
  always_comb begin
    logic [31:0] live;
    live = flags_reg;
    live[fsirq_pkg::BIT_RXFNE] = !rx_empty;
    irq = |(live & mask_reg & allowed_bits);
  end

endmodule

// ---- tb/fsirq_properties.sv ----
`timescale 1ns/10ps
module fsirq_properties (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic host_mode,
  input wire logic [31:0] event_pulses,
  input wire logic rx_push,
  input wire logic rx_full,
  input wire logic irq
);
  logic wr_reg;
  logic pop_reg;
  logic [31:0] en_reg;
  wire logic acc = hsel && htrans[1] && hready;
  wire logic ev_any = |event_pulses;
  // Mask mirror drops the bits the current mode refuses
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_reg <= 1'h0;
      pop_reg <= 1'h0;
      en_reg <= 32'h0;
    end else begin
      wr_reg <= acc && hwrite && haddr == fsirq_pkg::MASK_OFFSET;
      pop_reg <= acc && !hwrite && haddr == fsirq_pkg::POP_OFFSET;
      if (wr_reg) begin
        en_reg <= hwdata & fsirq_pkg::MASK_IMPL &
          (host_mode ? ~fsirq_pkg::DEV_ONLY : ~fsirq_pkg::HOST_ONLY);
      end
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_reset_quiet: assert property ($rose(hresetn) |-> !irq)
    else $error("irq after reset");
  a_mask_empty: assert property (en_reg == 32'h0 |-> !irq)
    else $error("irq with empty mask");
  a_rxne_gate: assert property (rx_push && en_reg[4] |=> irq)
    else $error("rx entry not signalled");
  a_shared_gate: assert property (|(event_pulses[3:1] & en_reg[3:1]) |=> irq)
    else $error("shared source not signalled");
  a_dev_gate: assert property (|(event_pulses & en_reg & fsirq_pkg::DEV_ONLY)
    && !host_mode && !$past(host_mode, 3) |=> irq) else $error("device source lost");
  a_host_gate: assert property (event_pulses[5] && en_reg[5] && host_mode
    && $past(host_mode, 3) |=> irq) else $error("host source lost");
  a_irq_cause: assert property ($rose(irq) |-> $past(ev_any) || $past(rx_push)
    || $past(wr_reg)) else $error("irq without cause");
  a_full_pop: assert property ($fell(rx_full) |-> $past(pop_reg))
    else $error("full dropped without pop");
  c_irq: cover property ($rose(irq));
  c_full: cover property ($rose(rx_full));
  c_pop: cover property ($fell(rx_full));
endmodule
bind fsirq_core fsirq_properties u_props (.*);

// ---- tb/tb_usb_core_irq_mask_and_rx_status_pop.sv ----
`timescale 1ns/10ps
module tb_usb_core_irq_mask_and_rx_status_pop;
  logic hclk = '0, hresetn = '0, hsel = '0, hwrite = '0, host_mode = '0, rx_push = '0;
  logic [1:0] htrans = '0;
  logic [31:0] haddr = '0, hwdata = '0, ev = '0, r, hrdata;
  logic [20:0] ent = '0;
  logic hreadyout, hresp, rx_full, irq;
  logic [31:0] q[$];
  int fails = 0, cmp_count = 0;
  always #20 hclk = ~hclk;
  fsirq_core #(.DEPTH(4)) uut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'h1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(fsirq_pkg::HSIZE_WORD),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .host_mode(host_mode), .event_pulses(ev), .rx_push(rx_push),
    .rx_entry(ent), .rx_full(rx_full), .irq(irq));
  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d);
    hsel <= 1'h1;
    haddr <= a;
    hwrite <= w;
    htrans <= fsirq_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    r = hrdata;
  endtask
  task automatic rd(input logic [31:0] a, e);
    bus(1'h0, a, 32'h0);
    chk(r, e);
  endtask
  task automatic wm(input logic [31:0] d);
    bus(1'h1, fsirq_pkg::MASK_OFFSET, d);
  endtask
  task automatic irq_is(input logic e);
    #1;
    chk({31'h0, irq}, {31'h0, e});
    @(posedge hclk);
  endtask
  task automatic pulse(input int b);
    ev <= 32'h1 << b;
    @(posedge hclk);
    ev <= 32'h0;
    @(posedge hclk);
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h7d89f434));
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    rd(fsirq_pkg::MASK_OFFSET, 32'h0);
    rd(fsirq_pkg::PEEK_OFFSET, 32'h0);
    for (int b = 1; b < 21; b++) begin
      if (fsirq_pkg::MASK_IMPL[b] && b != 4 && b != 5) begin
        pulse(b);
        irq_is(1'h0);
        rd(fsirq_pkg::FLAGS_OFFSET, 32'h1 << b);
        wm(32'h1 << b);
        irq_is(1'h1);
        rd(fsirq_pkg::MASK_OFFSET, 32'h1 << b);
        wm(32'h0);
        bus(1'h1, fsirq_pkg::FLAGS_OFFSET, 32'h1 << b);
      end
    end
    wm(32'h20);
    rd(fsirq_pkg::MASK_OFFSET, 32'h0);
    rd(fsirq_pkg::FLAGS_OFFSET, 32'h2);
    host_mode <= 1'h1;
    repeat (4) @(posedge hclk);
    wm(32'h0010_0000);
    rd(fsirq_pkg::MASK_OFFSET, 32'h0);
    wm(32'h20);
    rd(fsirq_pkg::MASK_OFFSET, 32'h20);
    pulse(5);
    irq_is(1'h1);
    wm(32'h0);
    bus(1'h1, fsirq_pkg::FLAGS_OFFSET, 32'h22);
    host_mode <= 1'h0;
    repeat (4) @(posedge hclk);
    $display("mask tests done");
    wm(32'h10);
    repeat (4) begin
      ent <= 21'($urandom);
      rx_push <= 1'h1;
      @(posedge hclk);
      q.push_back({11'h0, ent});
    end
    rx_push <= 1'h0;
    irq_is(1'h1);
    chk({31'h0, rx_full}, 32'h1);
    rd(fsirq_pkg::FLAGS_OFFSET, 32'h10);
    rd(fsirq_pkg::PEEK_OFFSET, q[0]);
    rd(fsirq_pkg::PEEK_OFFSET, q[0]);
    while (q.size() > 0) rd(fsirq_pkg::POP_OFFSET, q.pop_front());
    irq_is(1'h0);
    rd(fsirq_pkg::POP_OFFSET, 32'h0);
    $display("fifo tests done");
    tally_and_finish();
  end
  initial begin
    #400000;
    fails++;
    tally_and_finish();
  end
endmodule
